/* hw/converter_ctrl3_status_regs.sv */
// third configuration register and sticky status register of a step-down converter
// assumes a serial engine issuing one-cycle read and write strobes with an 8-bit offset
//
// What this block does
// - config bits 7..3 reserved, read zero; software writes zeros
// - config bit 2 enables droop compensation; reset value per variant
// - config bit 1 set turns off enable pulldown and sync output
// - pg blanking bit clear: power-good follows window comparator always
// - pg blanking bit set: power-good released during voltage transition
// - status bits 7..6 reserved, read zero, host ignores them
// - status bit 5 latches retry restart events until read
// - status bit 4 latches current limit events until read
// - status bit 3 latches temperature warning events until read
// - status bit 2 latches overtemperature shutdown events until read
// - status bit 1 latches output undervoltage events until read
// - status bit 0 latches output overvoltage events until read
// - status register at offset 4, resets to zero
// - status read returns flags then clears them
`timescale 1ns/1ps
module converter_ctrl3_status_regs
    import conv_regs_pkg::*;
#(
    parameter logic DROOP_RST = conv_regs_pkg::DROOP_RST_DEF
) (
    // clock and reset
    input  wire logic                            sys_clk_i,
    input  wire logic                            rst_b_i,
    // register access
    input  wire logic [conv_regs_pkg::ADDR_W-1:0] reg_addr_i,
    input  wire logic [conv_regs_pkg::DATA_W-1:0] reg_wdata_i,
    input  wire logic                            reg_wr_i,
    input  wire logic                            reg_rd_i,
    output logic      [conv_regs_pkg::DATA_W-1:0] reg_rdata_o,
    // converter events
    input  wire logic                            retry_restart_event_i,
    input  wire logic                            current_limit_event_i,
    input  wire logic                            temperature_warning_event_i,
    input  wire logic                            overtemperature_shutdown_event_i,
    input  wire logic                            output_undervoltage_event_i,
    input  wire logic                            output_overvoltage_event_i,
    // analog side
    input  wire logic                            window_comp_ok_i,
    input  wire logic                            voltage_transition_i,
    output logic                                 droop_comp_enable_o,
    output logic                                 enable_pulldown_on_o,
    output logic                                 sync_clock_output_en_o,
    output logic                                 power_good_output_o,
    output logic                                 power_good_output_oe_o
);
    import conv_regs_pkg::*;

    logic             droop_r;
    logic             standalone_r;
    logic             pg_blank_r;
    logic [EVT_W-1:0] events;
    logic [EVT_W-1:0] flags;
    logic             cfg_sel;
    logic             stat_sel;
    logic [7:0]       cfg_view;
    logic [7:0]       stat_view;

    assign cfg_sel  = (reg_addr_i == CFG3_OFFSET);
    assign stat_sel = (reg_addr_i == STATUS_OFFSET);

    assign events[EV_RETRY] = retry_restart_event_i;
    assign events[EV_CURRENT_LIMIT_EVENT]  = current_limit_event_i;
    assign events[EV_TEMPERATURE_WARNING_EVENT] = temperature_warning_event_i;
    assign events[EV_OVERTEMPERATURE_SHUTDOWN_EVENT] = overtemperature_shutdown_event_i;
    assign events[EV_UV]    = output_undervoltage_event_i;
    assign events[EV_OV]    = output_overvoltage_event_i;

    event_sticky_flags #(
        .W (EVT_W)
    ) u_flags (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .event_i   (events),
        .clear_i   (reg_rd_i && stat_sel),
        .flags_o   (flags)
    );

    // reserved bits only come from zeros, whatever software writes
    always_comb begin
        cfg_view                 = 8'h00;
        cfg_view[DROOP_BIT]      = droop_r;
        cfg_view[STANDALONE_BIT] = standalone_r;
        cfg_view[PG_BLANK_BIT]   = pg_blank_r;
        stat_view                = {2'h0, flags};
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            droop_r      <= DROOP_RST;
            standalone_r <= STANDALONE_RST;
            pg_blank_r   <= PG_BLANK_RST;
        end else if (reg_wr_i && cfg_sel) begin
            droop_r      <= reg_wdata_i[DROOP_BIT];
            standalone_r <= reg_wdata_i[STANDALONE_BIT];
            pg_blank_r   <= reg_wdata_i[PG_BLANK_BIT];
        end
    end

    // read data: pre-clear flag values are returned, unmapped offsets read zero
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= STATUS_RST;
        end else if (reg_rd_i) begin
            if (stat_sel) begin
                reg_rdata_o <= stat_view;
            end else if (cfg_sel) begin
                reg_rdata_o <= cfg_view;
            end else begin
                reg_rdata_o <= 8'h00;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            droop_comp_enable_o    <= 1'b0;
            enable_pulldown_on_o   <= 1'b0;
            sync_clock_output_en_o <= 1'b0;
        end else begin
            droop_comp_enable_o    <= droop_r;
            enable_pulldown_on_o   <= !standalone_r;
            sync_clock_output_en_o <= !standalone_r;
        end
    end

    // open-drain power-good: pull low when not ok, release when ok or blanked
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            power_good_output_o    <= 1'b0;
            power_good_output_oe_o <= 1'b0;
        end else begin
            power_good_output_o <= 1'b0;
            if (pg_blank_r && voltage_transition_i) begin
                power_good_output_oe_o <= 1'b0;
            end else begin
                power_good_output_oe_o <= !window_comp_ok_i;
            end
        end
    end

    property p_cfg_reserved_zero;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (reg_rd_i && cfg_sel) |=> (reg_rdata_o[7:3] == 5'h00);
    endproperty
    a_cfg_reserved_zero: assert property (p_cfg_reserved_zero)
        else $error("config reserved bits read nonzero");

    property p_stat_reserved_zero;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (reg_rd_i && stat_sel) |=> (reg_rdata_o[7:6] == 2'h0);
    endproperty
    a_stat_reserved_zero: assert property (p_stat_reserved_zero)
        else $error("status reserved bits read nonzero");

    property p_droop_follows;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (reg_wr_i && cfg_sel) |=> ##1 (droop_comp_enable_o == $past(reg_wdata_i[DROOP_BIT], 2));
    endproperty
    a_droop_follows: assert property (p_droop_follows)
        else $error("droop enable does not follow write");

    property p_standalone_gates;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (reg_wr_i && cfg_sel) |=> ##1 (enable_pulldown_on_o == !$past(reg_wdata_i[STANDALONE_BIT], 2)
                                     && sync_clock_output_en_o == enable_pulldown_on_o);
    endproperty
    a_standalone_gates: assert property (p_standalone_gates)
        else $error("standalone bit does not gate pulldown and sync");

    property p_pg_follows;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (!pg_blank_r) |=> (power_good_output_oe_o == !$past(window_comp_ok_i));
    endproperty
    a_pg_follows: assert property (p_pg_follows)
        else $error("power-good not following comparator");

    property p_pg_blank;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (pg_blank_r && voltage_transition_i) |=> !power_good_output_oe_o;
    endproperty
    a_pg_blank: assert property (p_pg_blank)
        else $error("power-good driven during blanked transition");

    sequence s_event_seen;
        !(reg_rd_i && stat_sel) && current_limit_event_i;
    endsequence
    property p_current_limit_event_sticky;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        s_event_seen ##1 (reg_rd_i && stat_sel) |=> reg_rdata_o[EV_CURRENT_LIMIT_EVENT];
    endproperty
    a_current_limit_event_sticky: assert property (p_current_limit_event_sticky)
        else $error("current limit flag lost before read");

    property p_read_clears;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (reg_rd_i && stat_sel && events == '0) |=> (flags == '0);
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("status read did not clear flags");

    property p_event_wins;
        @(posedge sys_clk_i) disable iff (!rst_b_i)
        (reg_rd_i && stat_sel && overtemperature_shutdown_event_i) |=> flags[EV_OVERTEMPERATURE_SHUTDOWN_EVENT];
    endproperty
    a_event_wins: assert property (p_event_wins)
        else $error("event lost in clearing read");
endmodule : converter_ctrl3_status_regs

/* common/conv_regs_pkg.sv */
// constants for the third configuration register and the sticky event status register
// assumes an external serial engine that presents byte-wide register reads and writes
package conv_regs_pkg;
    localparam int         DATA_W          = 8;
    localparam int         ADDR_W          = 8;
    localparam int         EVT_W           = 6;
    localparam logic [7:0] CFG3_OFFSET     = 8'h03;
    localparam logic [7:0] STATUS_OFFSET   = 8'h04;
    localparam logic [7:0] CFG3_RW_MASK    = 8'h07;
    localparam logic [7:0] STATUS_RST      = 8'h00;
    localparam int         DROOP_BIT       = 2;
    localparam int         STANDALONE_BIT  = 1;
    localparam int         PG_BLANK_BIT    = 0;
    localparam int         EV_RETRY        = 5;
    localparam int         EV_CURRENT_LIMIT_EVENT         = 4;
    localparam int         EV_TEMPERATURE_WARNING_EVENT        = 3;
    localparam int         EV_OVERTEMPERATURE_SHUTDOWN_EVENT        = 2;
    localparam int         EV_UV           = 1;
    localparam int         EV_OV           = 0;
    localparam logic       DROOP_RST_DEF   = 1'b0;
    localparam logic       STANDALONE_RST  = 1'b0;
    localparam logic       PG_BLANK_RST    = 1'b0;
endpackage : conv_regs_pkg

/* hw/event_sticky_flags.sv */
// sticky event flags, cleared by a status read; a new event wins over the clear
// assumes event inputs are synchronous one-cycle or level strobes
`timescale 1ns/1ps
module event_sticky_flags #(
    parameter int W = 6
) (
    // clock and reset
    input  wire logic         sys_clk_i,
    input  wire logic         rst_b_i,
    // events and clear
    input  wire logic [W-1:0] event_i,
    input  wire logic         clear_i,
    // flags
    output logic      [W-1:0] flags_o
);
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flags_o <= '0;
        end else if (clear_i) begin
            flags_o <= event_i;
        end else begin
            flags_o <= flags_o | event_i;
        end
    end
endmodule : event_sticky_flags

/* verif/serial_host_model.sv */
// host model: byte-wide register reads and writes, one strobe per access
// assumes the block takes a strobe on a rising edge; strobes move on falling edges
`timescale 1ns/1ps
module serial_host_model (
    // clock
    input  wire logic       sys_clk_i,
    // register access
    output logic      [7:0] reg_addr_o,
    output logic      [7:0] reg_wdata_o,
    output logic            reg_wr_o,
    output logic            reg_rd_o
);
    initial begin
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
    end

    // single-device bench only, so the stand-alone bit may be set
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        reg_addr_o  = a;
        reg_wdata_o = d;
        reg_wr_o    = 1'b1;
        @(negedge sys_clk_i);
        reg_wr_o    = 1'b0;
        reg_wdata_o = ~d;
        // outputs follow two edges after the write
        repeat (2) @(negedge sys_clk_i);
    endtask : wr_reg

    // idle cycle after each read keeps the answer standing for the checker
    task automatic rd_reg(input logic [7:0] a);
        @(negedge sys_clk_i);
        reg_addr_o = a;
        reg_rd_o   = 1'b1;
        @(negedge sys_clk_i);
        reg_rd_o = 1'b0;
        @(negedge sys_clk_i);
    endtask : rd_reg
endmodule : serial_host_model

/* verif/converter_ctrl3_status_regs_tb.sv */
// self-checking bench for the configuration and sticky status registers
// assumes the host model above and registered read data one edge after the read
`timescale 1ns/1ps
module converter_ctrl3_status_regs_tb;
    import conv_regs_pkg::*;
    logic        sys_clk_i = 1'b0;
    logic        rst_b_i   = 1'b0;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        wr;
    logic        rd;
    logic        win       = 1'b1;
    logic        trans     = 1'b0;
    logic [5:0]  evt       = 6'h00;
    logic [5:0]  e;
    logic        droop;
    logic        pd;
    logic        sync;
    logic        pgo;
    logic        pgoe;
    logic [12:0] exp_q[$];
    logic [7:0]  cfg       = 8'h04;
    int          fails       = 0;
    int          checks_done = 0;
    int          cyc         = 0;

    always #25 sys_clk_i = ~sys_clk_i;

    serial_host_model serial_host_model_inst (.sys_clk_i(sys_clk_i), .reg_addr_o(addr),
        .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));

    // droop reset taken as 1 so the variant value is visible
    converter_ctrl3_status_regs #(.DROOP_RST(1'b1)) converter_ctrl3_status_regs_inst (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .retry_restart_event_i(evt[EV_RETRY]), .current_limit_event_i(evt[EV_CURRENT_LIMIT_EVENT]),
        .temperature_warning_event_i(evt[EV_TEMPERATURE_WARNING_EVENT]),
        .overtemperature_shutdown_event_i(evt[EV_OVERTEMPERATURE_SHUTDOWN_EVENT]),
        .output_undervoltage_event_i(evt[EV_UV]), .output_overvoltage_event_i(evt[EV_OV]),
        .window_comp_ok_i(win), .voltage_transition_i(trans), .droop_comp_enable_o(droop),
        .enable_pulldown_on_o(pd), .sync_clock_output_en_o(sync),
        .power_good_output_o(pgo), .power_good_output_oe_o(pgoe));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict

    // read data plus every configuration-driven output, noted before the read
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] d);
        exp_q.push_back({d, cfg[2], ~cfg[1], ~cfg[1], 1'b0, (cfg[0] && trans) ? 1'b0 : ~win});
        serial_host_model_inst.rd_reg(a);
    endtask : rd_chk

    task automatic pulse(input logic [5:0] v);
        @(negedge sys_clk_i);
        evt = v;
        @(negedge sys_clk_i);
        evt = 6'h00;
    endtask : pulse

    always @(posedge sys_clk_i) begin
        logic [12:0] x;
        if (rd === 1'b1) begin
            repeat (2) @(negedge sys_clk_i);
            x = exp_q.pop_front();
            checks_done++;
            if ({rdata, droop, pd, sync, pgo, pgoe} !== x) begin
                $display("unexpected t=%0t got %h exp %h", $time,
                         {rdata, droop, pd, sync, pgo, pgoe}, x);
                fails++;
            end
        end
    end

    // whole run is well under 2000 cycles
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            give_verdict();
        end
    end

    initial begin
        void'($urandom(32'h79fb));
        repeat (4) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        rst_b_i = 1'b1;
        rd_chk(STATUS_OFFSET, STATUS_RST);
        rd_chk(CFG3_OFFSET, cfg);
        for (int i = 0; i < 6; i++) begin
            pulse(6'h01 << i);
            rd_chk(STATUS_OFFSET, {2'b00, 6'h01 << i});
            rd_chk(STATUS_OFFSET, 8'h00);
        end
        // overtemperature_shutdown_event kept out of e so the clearing read below always meets it
        e = 6'($urandom) & 6'h3b;
        pulse(e);
        pulse(6'h3f ^ e);
        rd_chk(STATUS_OFFSET, 8'h3f);
        fork
            rd_chk(STATUS_OFFSET, 8'h00);
            pulse(~e);
        join
        rd_chk(STATUS_OFFSET, {2'b00, ~e});
        // event one cycle ahead of the read must show in that read
        fork
            pulse(6'h10);
            begin
                @(negedge sys_clk_i);
                rd_chk(STATUS_OFFSET, 8'h10);
            end
        join
        rd_chk(STATUS_OFFSET, 8'h00);
        for (int v = 0; v < 16; v++) begin
            win   = 1'($urandom);
            trans = v[3];
            serial_host_model_inst.wr_reg(CFG3_OFFSET, 8'hf8 | 8'(v[2:0]));
            cfg = {5'b00000, v[2:0]};
            rd_chk(CFG3_OFFSET, cfg);
        end
        serial_host_model_inst.wr_reg(8'h05, 8'hff);
        rd_chk(8'h05, 8'h00);
        rd_chk(CFG3_OFFSET, cfg);
        repeat (3) @(negedge sys_clk_i);
        give_verdict();
    end
endmodule : converter_ctrl3_status_regs_tb
